// ---- design/dcct_timers.sv ----
`timescale 1ns/1ps
module dcct_timers (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] t0_mode,
   input wire logic [1:0] t1_mode,
   input wire logic t0_run,
   input wire logic t1_run,
   input wire logic t0_gate_enable,
   input wire logic t1_gate_enable,
   input wire logic t0_counter_select,
   input wire logic t1_counter_select,
   input wire logic t0_clock_select,
   input wire logic t1_clock_select,
   input wire logic [1:0] clock_scale,
   input wire logic ext_clk_tick,
   input wire logic gate_line_a,
   input wire logic gate_line_b,
   input wire logic gate_a_polarity,
   input wire logic gate_b_polarity,
   input wire logic event_pin_a,
   input wire logic event_pin_b,
   input wire logic t0_irq_enable,
   input wire logic t1_irq_enable,
   input wire logic t0_low_wr,
   input wire logic t0_high_wr,
   input wire logic t1_low_wr,
   input wire logic t1_high_wr,
   input wire logic [7:0] wr_data,
   input wire logic t0_flag_wr,
   input wire logic t1_flag_wr,
   input wire logic t0_flag_wdata,
   input wire logic t1_flag_wdata,
   input wire logic t0_irq_ack,
   input wire logic t1_irq_ack,
   output logic [7:0] t0_count_low,
   output logic [7:0] t0_count_high,
   output logic [7:0] t1_count_low,
   output logic [7:0] t1_count_high,
   output logic t0_overflow_flag,
   output logic t1_overflow_flag,
   output logic t0_irq,
   output logic t1_irq,
   output logic t0_ovf_strobe,
   output logic t1_ovf_strobe
);

   // ***************************************************************
   // Shared prescaled clock
   // ***************************************************************
   logic pre_tick;

   dcct_prescaler #(.CNT_W(6)) u_pre (
      .mclk(mclk),
      .reset_n(reset_n),
      .scale_sel(clock_scale),
      .ext_clk_tick(ext_clk_tick),
      .tick(pre_tick)
   );

   // ***************************************************************
   // Event pin edge detection
   // ***************************************************************
   // Pins are taken as synchronous, so one stage of history suffices.
   // A falling edge is seen if each level lasts at least one clock.
   logic ev_a_q;
   logic ev_b_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ev_a_q <= 1'b1;
         ev_b_q <= 1'b1;
      end else begin
         ev_a_q <= event_pin_a;
         ev_b_q <= event_pin_b;
      end
   end

   logic fall_a;
   logic fall_b;
   assign fall_a = ev_a_q & ~event_pin_a;
   assign fall_b = ev_b_q & ~event_pin_b;

   // ***************************************************************
   // Helper functions
   // ***************************************************************
   // Chooses the tick for a timer from its source bits.
   function automatic logic pick_tick(input logic ctr_sel, input logic clk_sel,
                                      input logic fall, input logic pre);
      if (ctr_sel) begin
         pick_tick = fall;
      end else if (clk_sel) begin
         pick_tick = 1'b1;
      end else begin
         pick_tick = pre;
      end
   endfunction : pick_tick

   // Run qualification from run, gate, gate line and polarity.
   function automatic logic run_ok(input logic run, input logic gate,
                                   input logic line, input logic pol);
      run_ok = run & (~gate | (line ^ pol));
   endfunction : run_ok

   // ***************************************************************
   // Enables and ticks
   // ***************************************************************
   logic split;
   logic t0_en;
   logic t0_tick;
   logic t0h_tick;
   logic t1_en;
   logic t1_tick;

   assign split = (dcct_pkg::dcct_mode_t'(t0_mode) == dcct_pkg::DCCT_MODE_SPLIT);
   assign t0_en = run_ok(t0_run, t0_gate_enable, gate_line_a, gate_a_polarity);
   assign t0_tick = t0_en & pick_tick(t0_counter_select, t0_clock_select, fall_a, pre_tick);
   // Split high byte is a pure timer gated by the second run bit only.
   assign t0h_tick = t1_run & pick_tick(1'b0, t0_clock_select, 1'b0, pre_tick);

   // While split, the second timer runs off its mode and never sees the pin.
   always_comb begin
      if (split) begin
         t1_en = (dcct_pkg::dcct_mode_t'(t1_mode) != dcct_pkg::DCCT_MODE_SPLIT);
         t1_tick = t1_en & pick_tick(1'b0, t1_clock_select, 1'b0, pre_tick);
      end else begin
         t1_en = run_ok(t1_run, t1_gate_enable, gate_line_b, gate_b_polarity);
         t1_tick = t1_en & pick_tick(t1_counter_select, t1_clock_select, fall_b, pre_tick);
      end
   end

   // ***************************************************************
   // Wrap detection
   // ***************************************************************
   // Reports whether the next tick wraps the count for the given mode.
   function automatic logic wraps(input logic [1:0] mode, input logic [7:0] lo,
                                  input logic [7:0] hi);
      case (dcct_pkg::dcct_mode_t'(mode))
         dcct_pkg::DCCT_MODE_13: wraps = (hi == dcct_pkg::BYTE_ONES) &&
            (lo[dcct_pkg::LOW5_MSB:0] == dcct_pkg::LOW5_ONES);
         dcct_pkg::DCCT_MODE_16: wraps = (hi == dcct_pkg::BYTE_ONES) &&
            (lo == dcct_pkg::BYTE_ONES);
         default: wraps = (lo == dcct_pkg::BYTE_ONES);
      endcase
   endfunction : wraps

   logic t0_wrap;
   logic t0h_wrap;
   logic t1_wrap;

   assign t0_wrap = t0_tick && wraps(t0_mode, t0_count_low, t0_count_high);
   assign t0h_wrap = split && t0h_tick && (t0_count_high == dcct_pkg::BYTE_ONES);
   // While timer 0 is split, a second timer parked in the split mode never ticks, so it never wraps.
   assign t1_wrap = t1_tick && wraps(t1_mode, t1_count_low, t1_count_high);

   // ***************************************************************
   // Count update
   // ***************************************************************
   // Next count value for one timer, software writes aside.
   function automatic logic [15:0] step(input logic [1:0] mode, input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [12:0] c13;
      c13 = {hi, lo[dcct_pkg::LOW5_MSB:0]} + 13'h0001;
      case (dcct_pkg::dcct_mode_t'(mode))
         // Low byte bits 7..5 are left as they were; readers mask them.
         dcct_pkg::DCCT_MODE_13: step = {c13[12:5], lo[7:5], c13[4:0]};
         dcct_pkg::DCCT_MODE_16: step = {hi, lo} + 16'h0001;
         dcct_pkg::DCCT_MODE_RELOAD: step = (lo == dcct_pkg::BYTE_ONES) ?
            {hi, hi} : {hi, lo + 8'h01};
         default: step = {hi, lo + 8'h01};
      endcase
   endfunction : step

   // The next value is computed once so that both bytes slice one result.
   logic [15:0] t0_next;
   assign t0_next = step(t0_mode, t0_count_low, t0_count_high);

   // Timer 0 count; the run bit alone never disturbs it.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         t0_count_low <= dcct_pkg::BYTE_ZERO;
         t0_count_high <= dcct_pkg::BYTE_ZERO;
      end else begin
         if (t0_tick) begin
            t0_count_low <= t0_next[7:0];
            if (!split) begin
               t0_count_high <= t0_next[15:8];
            end
         end
         if (split && t0h_tick) begin
            t0_count_high <= t0_count_high + 8'h01;
         end
         if (t0_low_wr) begin
            t0_count_low <= wr_data;
         end
         if (t0_high_wr) begin
            t0_count_high <= wr_data;
         end
      end
   end

   // Timer 1 count, same structure with its own bytes.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         t1_count_low <= dcct_pkg::BYTE_ZERO;
         t1_count_high <= dcct_pkg::BYTE_ZERO;
      end else begin
         if (t1_tick) begin
            {t1_count_high, t1_count_low} <= step(t1_mode, t1_count_low, t1_count_high);
         end
         if (t1_low_wr) begin
            t1_count_low <= wr_data;
         end
         if (t1_high_wr) begin
            t1_count_high <= wr_data;
         end
      end
   end

   // ***************************************************************
   // Flags, interrupts and strobes
   // ***************************************************************
   logic t0_set;
   logic t1_set;

   assign t0_set = t0_wrap;
   // While split only the high byte of timer 0 may set the second flag.
   assign t1_set = split ? t0h_wrap : t1_wrap;

   // Hardware set wins over a same-cycle software or acknowledge clear.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         t0_overflow_flag <= 1'b0;
         t1_overflow_flag <= 1'b0;
      end else begin
         if (t0_set) begin
            t0_overflow_flag <= 1'b1;
         end else if (t0_flag_wr) begin
            t0_overflow_flag <= t0_flag_wdata;
         end else if (t0_irq_ack) begin
            t0_overflow_flag <= 1'b0;
         end
         if (t1_set) begin
            t1_overflow_flag <= 1'b1;
         end else if (t1_flag_wr) begin
            t1_overflow_flag <= t1_flag_wdata;
         end else if (t1_irq_ack) begin
            t1_overflow_flag <= 1'b0;
         end
      end
   end

   assign t0_irq = t0_overflow_flag & t0_irq_enable;
   assign t1_irq = t1_overflow_flag & t1_irq_enable;

   // Strobes are registered, one cycle after the wrapping tick.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         t0_ovf_strobe <= 1'b0;
         t1_ovf_strobe <= 1'b0;
      end else begin
         t0_ovf_strobe <= t0_wrap;
         t1_ovf_strobe <= t1_wrap;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   // Byte writes are left out of most antecedents because a write beats a tick.
   wrap13_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (t0_tick && !t0_low_wr && !t0_high_wr &&
       dcct_pkg::dcct_mode_t'(t0_mode) == dcct_pkg::DCCT_MODE_13 &&
       t0_count_high == 8'hff && t0_count_low[4:0] == 5'h1f)
      |=> t0_overflow_flag && t0_count_high == 8'h00 && t0_count_low[4:0] == 5'h00)
      else $error("13-bit wrap did not flag and clear");
   wrap16_t1_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (t1_tick && !split && !t1_low_wr && !t1_high_wr &&
       dcct_pkg::dcct_mode_t'(t1_mode) == dcct_pkg::DCCT_MODE_16 &&
       {t1_count_high, t1_count_low} == 16'hffff)
      |=> t1_overflow_flag && {t1_count_high, t1_count_low} == 16'h0000)
      else $error("16-bit wrap did not flag and clear");
   reload_copy_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (t1_tick && !split && !t1_low_wr && !t1_high_wr &&
       dcct_pkg::dcct_mode_t'(t1_mode) == dcct_pkg::DCCT_MODE_RELOAD &&
       t1_count_low == 8'hff)
      |=> t1_count_low == $past(t1_count_high) && $stable(t1_count_high))
      else $error("auto-reload copy wrong");
   gate_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (t0_run && t0_gate_enable && gate_line_a == gate_a_polarity) |-> !t0_tick)
      else $error("gated timer counted while stopped");
   run_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!t0_run && !t0_low_wr && !t0_high_wr && !split) |=> $stable(t0_count_low))
      else $error("timer counted with run clear");
   run_resume_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !t0_run ##1 (t0_tick && !t0_low_wr && !t0_high_wr &&
       dcct_pkg::dcct_mode_t'(t0_mode) == dcct_pkg::DCCT_MODE_16 &&
       t0_count_low != dcct_pkg::BYTE_ONES)
      |=> t0_count_low == $past(t0_count_low) + 8'h01)
      else $error("run bit disturbed the count");
   event_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (t0_counter_select && t0_en && !t0_low_wr && !t0_high_wr &&
       dcct_pkg::dcct_mode_t'(t0_mode) == dcct_pkg::DCCT_MODE_16 &&
       $past(event_pin_a) && !event_pin_a && t0_count_low != 8'hff)
      |=> t0_count_low == $past(t0_count_low) + 8'h01)
      else $error("falling edge not counted");
   // Split checks: the second timer keeps its strobe but loses its flag.
   split_nflag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (split && t1_wrap && !t0h_wrap && !t1_flag_wr && !t1_irq_ack)
      |=> t1_ovf_strobe && $stable(t1_overflow_flag))
      else $error("split second timer misbehaved");
   split_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (split && t0h_tick && !t0_high_wr && t0_count_high == dcct_pkg::BYTE_ONES)
      |=> t1_overflow_flag && t0_count_high == dcct_pkg::BYTE_ZERO)
      else $error("split high byte wrap not flagged");
   split_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (split && t0_tick && !t0_low_wr && t0_count_low == dcct_pkg::BYTE_ONES)
      |=> t0_overflow_flag && t0_count_low == dcct_pkg::BYTE_ZERO)
      else $error("split low byte wrap not flagged");
   split_t1_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (split && t1_clock_select && !t1_low_wr && !t1_high_wr &&
       dcct_pkg::dcct_mode_t'(t1_mode) == dcct_pkg::DCCT_MODE_16 &&
       t1_count_low != dcct_pkg::BYTE_ONES)
      |=> t1_count_low == $past(t1_count_low) + 8'h01)
      else $error("second timer idle while split");
   split_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (split && dcct_pkg::dcct_mode_t'(t1_mode) == dcct_pkg::DCCT_MODE_SPLIT
       && !t1_low_wr && !t1_high_wr) |=> $stable({t1_count_high, t1_count_low}))
      else $error("second timer ran in split mode");
   // Flag and strobe checks.
   irq_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
      t1_irq == (t1_overflow_flag && t1_irq_enable))
      else $error("interrupt not tied to flag and enable");
   flag_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (t0_overflow_flag && !t0_flag_wr && !t0_irq_ack) |=> t0_overflow_flag)
      else $error("flag cleared without cause");
   set_wins_a: assert property (@(posedge mclk) disable iff (!reset_n)
      t0_set |=> t0_overflow_flag)
      else $error("flag clear beat a wrap");
   strobe_a: assert property (@(posedge mclk) disable iff (!reset_n)
      t0_wrap |=> t0_ovf_strobe ##1 !t0_ovf_strobe || $past(t0_wrap))
      else $error("overflow strobe missing");
   t1_strobe_a: assert property (@(posedge mclk) disable iff (!reset_n)
      t1_wrap |=> t1_ovf_strobe)
      else $error("second overflow strobe missing");

endmodule : dcct_timers

// ---- design/dcct_pkg.sv ----
// How it works
// - 13-bit mode: high byte top eight, low five.
// - 13-bit wrap sets flag, may interrupt.
// - Counter select counts event pin falling edges.
// - Otherwise system clock or prescaled clock tick.
// - Run bit required; gate zero means run alone.
// - Gated: count while gate line differs polarity.
// - Setting run never clears or reloads count.
// - Second timer mirrors first with own bits.
// - 16-bit mode wraps from all ones.
// - Auto-reload: low counts, wrap copies high in.
// - Split: low byte uses first timer controls.
// - Split: high byte timer, second run, flag.
// - Split: second timer no events, strobe continues.
// - Split: second runs unless its mode splits.
// - Interrupt needs flag and enable both set.
// - Overflow strobes exported to peripherals.
// - Prescale: sysclk/12, /4, /48, extclk/8.
package dcct_pkg;

   // ***************************************************************
   // Modes and scale selections
   // ***************************************************************
   typedef enum logic [1:0] {
      DCCT_MODE_13,
      DCCT_MODE_16,
      DCCT_MODE_RELOAD,
      DCCT_MODE_SPLIT
   } dcct_mode_t;

   localparam logic [1:0] SCALE_DIV12 = 2'h0;
   localparam logic [1:0] SCALE_DIV4 = 2'h1;
   localparam logic [1:0] SCALE_DIV48 = 2'h2;
   localparam logic [1:0] SCALE_EXT8 = 2'h3;

   localparam int DIV_12 = 12;
   localparam int DIV_4 = 4;
   localparam int DIV_48 = 48;
   localparam int DIV_EXT = 8;

   localparam int LOW5_MSB = 4;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [4:0] LOW5_ONES = 5'h1f;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage : dcct_pkg

// ---- design/dcct_prescaler.sv ----
`timescale 1ns/1ps
// Builds the shared prescaled tick from the system clock or the external clock tick.
module dcct_prescaler #(
   parameter int CNT_W = 6
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] scale_sel,
   input wire logic ext_clk_tick,
   output logic tick
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic adv;

   // The widest divider needs six bits; a narrower counter would truncate the limit of 47 and divide by the wrong ratio.
   if (CNT_W < 6) begin : g_cnt_w_check
      $error("dcct_prescaler: CNT_W too small for divide by 48");
   end

   // ***************************************************************
   // Divider selection
   // ***************************************************************
   // The external source only advances the divider on its own ticks.
   always_comb begin
      limit = CNT_W'(dcct_pkg::DIV_12 - 1);
      adv = 1'b1;
      if (scale_sel == dcct_pkg::SCALE_DIV4) begin
         limit = CNT_W'(dcct_pkg::DIV_4 - 1);
      end else if (scale_sel == dcct_pkg::SCALE_DIV48) begin
         limit = CNT_W'(dcct_pkg::DIV_48 - 1);
      end else if (scale_sel == dcct_pkg::SCALE_EXT8) begin
         limit = CNT_W'(dcct_pkg::DIV_EXT - 1);
         adv = ext_clk_tick;
      end
   end

   // A scale change mid-count may stretch one period; that is harmless.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (adv) begin
            if (cnt_q >= limit) begin
               cnt_q <= '0;
               tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

   div4_period_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (tick && scale_sel == dcct_pkg::SCALE_DIV4) ##1
      (scale_sel == dcct_pkg::SCALE_DIV4)[*3] |=> tick)
      else $error("divide by four period wrong");

endmodule : dcct_prescaler

// ---- verif/dcct_event_src.sv ----
`timescale 1ns/1ps
// ************************************************************
// Event pin source
// ************************************************************
module dcct_event_src (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic fire,
   output logic pin
);
   logic [2:0] cnt_q;

   // A request gives two low clocks, then at least three high clocks, so no falling edge comes faster
   // than a fifth of the system clock even when requests arrive back to back.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 3'h0;
      end else if (fire && cnt_q == 3'h0) begin
         cnt_q <= 3'h4;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end

   // The pin idles high, as a pulled-up input would.
   assign pin = (cnt_q < 3'h3);
endmodule : dcct_event_src

// ---- verif/test_dcct_timers.sv ----
`timescale 1ns/1ps
// ************************************************************
// Bench for the dual counter/timer
// ************************************************************
module test_dcct_timers;
   logic mclk;
   logic reset_n;
   logic [1:0] mode0, mode1, run, gate, csel, ksel, scale, gl, pol, fire, ev;
   logic [1:0] ien, lwr, hwr, fwr, fwd, ack, flag, irq, stb;
   logic ext;
   logic [7:0] wdat;
   logic [7:0] lo [2];
   logic [7:0] hi [2];
   int err_count, n_checks, k, s, t;
   int nstb [2];
   int dv [4];

   dcct_timers dut (.mclk(mclk), .reset_n(reset_n), .t0_mode(mode0), .t1_mode(mode1),
      .t0_run(run[0]), .t1_run(run[1]), .t0_gate_enable(gate[0]), .t1_gate_enable(gate[1]),
      .t0_counter_select(csel[0]), .t1_counter_select(csel[1]),
      .t0_clock_select(ksel[0]), .t1_clock_select(ksel[1]), .clock_scale(scale),
      .ext_clk_tick(ext), .gate_line_a(gl[0]), .gate_line_b(gl[1]),
      .gate_a_polarity(pol[0]), .gate_b_polarity(pol[1]),
      .event_pin_a(ev[0]), .event_pin_b(ev[1]),
      .t0_irq_enable(ien[0]), .t1_irq_enable(ien[1]),
      .t0_low_wr(lwr[0]), .t0_high_wr(hwr[0]), .t1_low_wr(lwr[1]), .t1_high_wr(hwr[1]),
      .wr_data(wdat), .t0_flag_wr(fwr[0]), .t1_flag_wr(fwr[1]),
      .t0_flag_wdata(fwd[0]), .t1_flag_wdata(fwd[1]),
      .t0_irq_ack(ack[0]), .t1_irq_ack(ack[1]),
      .t0_count_low(lo[0]), .t0_count_high(hi[0]), .t1_count_low(lo[1]),
      .t1_count_high(hi[1]), .t0_overflow_flag(flag[0]), .t1_overflow_flag(flag[1]),
      .t0_irq(irq[0]), .t1_irq(irq[1]), .t0_ovf_strobe(stb[0]), .t1_ovf_strobe(stb[1]));

   dcct_event_src src_a (.mclk(mclk), .reset_n(reset_n), .fire(fire[0]), .pin(ev[0]));
   dcct_event_src src_b (.mclk(mclk), .reset_n(reset_n), .fire(fire[1]), .pin(ev[1]));

   // The 200 MHz system clock.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Strobe pulses are counted so that a stuck or doubled pulse shows up.
   always @(posedge mclk) begin
      if (stb[0] === 1'b1) nstb[0]++;
      if (stb[1] === 1'b1) nstb[1]++;
   end

   // ************************************************************
   // Access and compare tasks
   // ************************************************************
   task automatic wr(input int ti, input logic hs, input logic [7:0] d);
      @(posedge mclk);
      wdat <= d;
      if (hs) hwr[ti] <= 1'b1;
      else lwr[ti] <= 1'b1;
      @(posedge mclk);
      hwr <= 2'h0;
      lwr <= 2'h0;
   endtask : wr

   task automatic load(input int ti, input logic [7:0] h, input logic [7:0] l);
      wr(ti, 1'b1, h);
      wr(ti, 1'b0, l);
   endtask : load

   // Run for n cycles; settling edges are left before the caller samples.
   task automatic tick(input int ti, input int n);
      @(posedge mclk);
      run[ti] <= 1'b1;
      repeat (n) @(posedge mclk);
      run[ti] <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask : tick

   task automatic flagop(input int ti, input logic a, input logic d);
      @(posedge mclk);
      if (a) ack[ti] <= 1'b1;
      else begin
         fwr[ti] <= 1'b1;
         fwd[ti] <= d;
      end
      @(posedge mclk);
      ack <= 2'h0;
      fwr <= 2'h0;
      #1;
   endtask : flagop

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk8

   task automatic chk1(input string n, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %b seen %b", n, e, g);
         err_count++;
      end
   endtask : chk1

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {mode0, mode1, run, gate, csel, scale, gl, pol, fire} = '0;
      {ien, lwr, hwr, fwr, fwd, ack, ext, wdat} = '0;
      ksel = 2'h3;
      reset_n = 1'b0;
      err_count = 0;
      n_checks = 0;
      dv = '{dcct_pkg::DIV_12, dcct_pkg::DIV_4, dcct_pkg::DIV_48, dcct_pkg::DIV_EXT};
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      ien <= 2'h3;
      mode0 <= 2'h1;
      mode1 <= 2'h1;
      #1;
      chk8("reset count", 8'h00, lo[0] | hi[0] | lo[1] | hi[1]);
      chk1("reset flag", 1'b0, flag[0] | flag[1]);
      // Full 16-bit wrap on each timer, resuming from a loaded value.
      for (t = 0; t < 2; t++) begin
         nstb[t] = 0;
         load(t, 8'hff, 8'hfe);
         tick(t, 1);
         chk8("resume low", 8'hff, lo[t]);
         tick(t, 1);
         chk8("wrap count", 8'h00, lo[t] | hi[t]);
         chk1("wrap flag", 1'b1, flag[t]);
         chk1("irq on", 1'b1, irq[t]);
         chk8("strobes", 8'h01, 8'(nstb[t]));
      end
      // Interrupt masking and flag clearing.
      @(posedge mclk);
      ien[0] <= 1'b0;
      #1;
      chk1("irq masked", 1'b0, irq[0]);
      chk1("flag sticky", 1'b1, flag[0]);
      flagop(0, 1'b0, 1'b0);
      chk1("sw clear", 1'b0, flag[0]);
      flagop(0, 1'b0, 1'b1);
      chk1("sw set", 1'b1, flag[0]);
      flagop(0, 1'b1, 1'b0);
      chk1("ack clear", 1'b0, flag[0]);
      flagop(1, 1'b1, 1'b0);
      // 13-bit carry and wrap.
      @(posedge mclk);
      mode0 <= 2'h0;
      load(0, 8'h00, 8'h1f);
      tick(0, 1);
      chk8("carry high", 8'h01, hi[0]);
      chk8("carry low", 8'h00, {3'h0, lo[0][4:0]});
      load(0, 8'hff, 8'h1f);
      tick(0, 1);
      chk8("wrap13", 8'h00, hi[0] | {3'h0, lo[0][4:0]});
      chk1("flag13", 1'b1, flag[0]);
      // Auto-reload of the low byte.
      flagop(0, 1'b1, 1'b0);
      @(posedge mclk);
      mode0 <= 2'h2;
      load(0, 8'h80, 8'hff);
      tick(0, 1);
      chk8("reload low", 8'h80, lo[0]);
      chk8("reload high", 8'h80, hi[0]);
      chk1("reload flag", 1'b1, flag[0]);
      tick(0, 3);
      chk8("after reload", 8'h83, lo[0]);
      // Gate line against polarity, every combination.
      @(posedge mclk);
      mode0 <= 2'h1;
      gate[0] <= 1'b1;
      for (k = 0; k < 4; k++) begin
         @(posedge mclk);
         gl[0] <= k[1];
         pol[0] <= k[0];
         load(0, 8'h00, 8'h00);
         tick(0, 4);
         chk8("gated", (k[1] ^ k[0]) ? 8'h04 : 8'h00, lo[0]);
      end
      @(posedge mclk);
      gate[0] <= 1'b0;
      load(0, 8'h00, 8'h00);
      repeat (4) @(posedge mclk);
      #1;
      chk8("run off", 8'h00, lo[0]);
      tick(0, 4);
      chk8("ungated", 8'h04, lo[0]);
      // Falling edges on both event pins.
      @(posedge mclk);
      csel <= 2'h3;
      load(0, 8'h00, 8'h00);
      load(1, 8'h00, 8'h00);
      @(posedge mclk);
      run <= 2'h3;
      for (k = 0; k < 3; k++) begin
         fire <= 2'h3;
         @(posedge mclk);
         fire <= 2'h0;
         repeat (5) @(posedge mclk);
      end
      run <= 2'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk8("events a", 8'h03, lo[0]);
      chk8("events b", 8'h03, lo[1]);
      // Every prescale selection over 96 enabled cycles.
      @(posedge mclk);
      csel <= 2'h0;
      ksel[0] <= 1'b0;
      for (s = 0; s < 4; s++) begin
         @(posedge mclk);
         scale <= s[1:0];
         ext <= (s == 3);
         load(0, 8'h00, 8'h00);
         tick(0, 96);
         k = 96 / dv[s];
         chk1("prescale", 1'b1, int'(lo[0]) >= k - 1 && int'(lo[0]) <= k + 1);
      end
      // Split operation. The second timer runs freely once split, so it is parked in
      // the split mode while loaded and released one edge before the run pulse.
      @(posedge mclk);
      ksel <= 2'h3;
      ext <= 1'b0;
      mode0 <= 2'h3;
      mode1 <= 2'h3;
      flagop(0, 1'b1, 1'b0);
      load(0, 8'h00, 8'hff);
      load(1, 8'hff, 8'hfe);
      nstb[1] = 0;
      @(posedge mclk);
      mode1 <= 2'h1;
      tick(1, 1);
      chk8("split high", 8'h01, hi[0]);
      chk8("t1 runs", 8'h02, lo[1] | hi[1]);
      chk1("t1 no flag", 1'b0, flag[1]);
      chk8("t1 strobe", 8'h01, 8'(nstb[1]));
      tick(0, 1);
      chk8("split low", 8'h00, lo[0]);
      chk1("split low flag", 1'b1, flag[0]);
      @(posedge mclk);
      mode1 <= 2'h3;
      load(1, 8'h00, 8'h00);
      load(0, 8'hff, 8'h00);
      tick(1, 2);
      chk8("t1 stopped", 8'h00, lo[1] | hi[1]);
      chk1("high wrap flag", 1'b1, flag[1]);
      stop_test();
   end
endmodule : test_dcct_timers
